// ---- hw/sfms_core.sv ----
// serial flash mode selection, status registers and write protection
//
// Behaviour
// R1 - single-line: sample instruction, address, data on rising sck edge
// R2 - single-line: change output data on falling sck edge
// R3 - host uses clock mode 0 or 3 only
// R4 - dual instructions use io0 and io1 as data lines
// R5 - quad instructions use io0 to io3 as data lines
// R6 - quad instructions run only with quad_lines_enable set
// R7 - opcode 38h enters four_line_command_mode only with quad_lines_enable
// R8 - four-line mode takes the opcode in two clocks on four lines
// R9 - modes exclusive; power-up and reset 99h start in single-line mode
// R10 - during power-on reset nothing is recognised
// R11 - power_up_write_delay blocks enable, program, erase, status writes
// R12 - write enable sets write_permit_latch at bit 1
// R13 - latch cleared by power-up, disable, program, erase, status write
// R14 - deep power-down ignores all but release
// R15 - busy bit 0 high while program, erase, status or security write runs
// R16 - while busy only status read and suspend are taken
// R17 - lock bits 00 free, 01 write-protect pin gates status writes
// R18 - lock bits 10 refuse writes until power cycle, then return to 00
// R19 - lock bits 11 refuse status writes for ever; here reset clears them to 00 as with 10
// R20 - quad_lines_enable turns protect and pause pins into data lines
// R21 - host avoids quad_lines_enable with those pins tied to a rail
// R22 - suspend 75h sets paused_op_flag, resume 7Ah or power cycle clears
// R23 - writes, programs, erases abort unless ended on whole byte
// R24 - reserved status bits read zero and ignore writes
`timescale 1ns/1ns
`default_nettype none
`include "sfms_defines.svh"

module sfms_core
  import sfms_pkg::*;
#(
  parameter int PUW_CYC = (`SFMS_PUW_NS + `SFMS_CLK_NS - 1) / `SFMS_CLK_NS,
  parameter int WSR_CYC = (`SFMS_WSR_NS + `SFMS_CLK_NS - 1) / `SFMS_CLK_NS,
  parameter int PROG_CYC = (`SFMS_PROG_NS + `SFMS_CLK_NS - 1) / `SFMS_CLK_NS,
  parameter int ERASE_CYC = (`SFMS_ERASE_NS + `SFMS_CLK_NS - 1) / `SFMS_CLK_NS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sck,
  input wire logic cs_b,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  output logic [15:0] status,
  output logic four_line_command_mode
);

  // instruction filter shared by both domains
  function automatic logic op_allowed(input logic [7:0] op, input logic deep, input logic busy);
    logic ok;
    ok = 1'b1;
    if (deep && op != `SFMS_OP_DEEP_RELEASE) begin
      ok = 1'b0; // see R14
    end else if (busy && op != `SFMS_OP_RD_STAT_LO && op != `SFMS_OP_RD_STAT_HI
                 && op != `SFMS_OP_SUSPEND) begin
      ok = 1'b0; // see R16
    end
    return ok;
  endfunction
  logic deep_q;
  logic wpl_q;
  logic lock_lo_q;
  logic lock_hi_q;
  logic quad_lines_enable_q;
  logic four_q;
  logic rst_arm_q;
  logic puw_done_q;
  logic [12:0] puw_cnt_q;
  logic [23:0] busy_cnt_q;
  sfms_op_t op_st_q;
  logic busy;
  logic paused;
  assign busy = (op_st_q == SFMS_RUN);
  assign paused = (op_st_q == SFMS_HELD);
  // deselect resets framing and output logic: sck may stop between frames
  logic link_rst_b;
  assign link_rst_b = rst_b & ~cs_b; // see R10
  sfms_cmd_t cmd_q;
  sfms_cmd_t cmd_now;
  logic [7:0] sh_q;
  logic [6:0] clks_q;
  logic in_frame_q;
  logic busy_s1_q;
  logic busy_s2_q;
  logic [2:0] in_step;
  logic [7:0] sh_d;
  logic [2:0] mod_d;

  // opcode over four lines in four-line mode, else one line
  always_comb begin
    // the last command outlives deselect so the clk side can act on it
    cmd_now = in_frame_q ? cmd_q : '0;
    in_step = four_q ? 3'd4 : 3'd1; // see R8
    sh_d = four_q ? {sh_q[3:0], io_in} : {sh_q[6:0], io_in[0]};
    mod_d = cmd_now.bit_mod + in_step;
  end

  always_ff @(posedge sck or negedge rst_b) begin // see R1
    if (!rst_b) begin
      sh_q <= 8'h00;
      cmd_q <= '0;
    end else begin
      sh_q <= sh_d;
      cmd_q <= cmd_now;
      cmd_q.bit_mod <= mod_d;
      if (mod_d == 3'd0) begin
        if (cmd_now.nbytes == 3'd0) begin
          cmd_q.op <= sh_d;
          cmd_q.valid <= 1'b1;
        end else if (cmd_now.nbytes == 3'd1) begin
          cmd_q.b1 <= sh_d;
        end else if (cmd_now.nbytes == 3'd2) begin
          cmd_q.b2 <= sh_d;
        end
        if (cmd_now.nbytes != 3'd7) begin
          cmd_q.nbytes <= cmd_now.nbytes + 3'd1;
        end
      end
    end
  end

  // busy may end mid-frame; the opcode clocks flush this pair
  always_ff @(posedge sck or negedge link_rst_b) begin
    if (!link_rst_b) begin
      busy_s1_q <= 1'b0;
      busy_s2_q <= 1'b0;
      clks_q <= 7'h00;
      in_frame_q <= 1'b0;
    end else begin
      busy_s1_q <= busy;
      busy_s2_q <= busy_s1_q;
      in_frame_q <= 1'b1;
      if (clks_q != 7'h7f) begin
        clks_q <= clks_q + 7'h01;
      end
    end
  end

  // output path; mode bits only change between frames, so they are stable here
  logic [7:0] osh_q;
  logic [3:0] ocnt_q;
  logic [3:0] io_out_q;
  logic [3:0] io_oe_q;
  logic rd_status;
  logic rd_array;
  logic rd_en;
  logic [3:0] out_w;
  logic [7:0] src;
  logic [7:0] byte_now;
  always_comb begin
    rd_status = cmd_q.op == `SFMS_OP_RD_STAT_LO || cmd_q.op == `SFMS_OP_RD_STAT_HI;
    rd_array = !four_q && clks_q >= `SFMS_DATA_START_CLKS &&
               (cmd_q.op == `SFMS_OP_DUAL_READ ||
                (cmd_q.op == `SFMS_OP_QUAD_READ && quad_lines_enable_q)); // see R6
    rd_en = in_frame_q && cmd_q.valid && op_allowed(cmd_q.op, deep_q, busy_s2_q) &&
            (rd_status || rd_array);
    if (four_q || cmd_q.op == `SFMS_OP_QUAD_READ) begin
      out_w = 4'd4; // see R5
    end else if (cmd_q.op == `SFMS_OP_DUAL_READ) begin
      out_w = 4'd2; // see R4
    end else begin
      out_w = 4'd1;
    end
    // array contents lie outside this block; reads return the erased pattern
    if (cmd_q.op == `SFMS_OP_RD_STAT_LO) begin
      src = status[7:0];
    end else if (cmd_q.op == `SFMS_OP_RD_STAT_HI) begin
      src = status[15:8];
    end else begin
      src = `SFMS_FILL_BYTE;
    end
    byte_now = (ocnt_q == 4'd0) ? src : osh_q;
  end

  always_ff @(negedge sck or negedge link_rst_b) begin // see R2
    if (!link_rst_b) begin
      osh_q <= 8'h00;
      ocnt_q <= 4'd0;
      io_out_q <= 4'h0;
      io_oe_q <= 4'h0;
    end else if (rd_en) begin
      osh_q <= byte_now << out_w;
      ocnt_q <= ((ocnt_q == 4'd0) ? 4'd8 : ocnt_q) - out_w;
      if (out_w == 4'd4) begin
        io_out_q <= byte_now[7:4];
        io_oe_q <= 4'hf;
      end else if (out_w == 4'd2) begin
        io_out_q <= {2'b00, byte_now[7:6]};
        io_oe_q <= 4'h3;
      end else begin
        io_out_q <= {2'b00, byte_now[7], 1'b0};
        io_oe_q <= 4'h2;
      end
    end else begin
      io_out_q <= 4'h0;
      io_oe_q <= 4'h0;
    end
  end

  assign io_out = io_out_q;
  assign io_oe = io_oe_q;
  logic [2:0] cs_sync_q;
  logic [2:0] wp_sync_q;
  logic cs_lvl_q;
  logic wp_lvl_q;
  logic frame_end;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_sync_q <= 3'b111;
      wp_sync_q <= 3'b000;
      cs_lvl_q <= 1'b1;
      wp_lvl_q <= 1'b0;
    end else begin
      cs_sync_q <= {cs_sync_q[1:0], cs_b};
      wp_sync_q <= {wp_sync_q[1:0], io_in[2]};
      if (cs_sync_q[1] == cs_sync_q[2]) begin
        cs_lvl_q <= cs_sync_q[2];
      end
      if (wp_sync_q[1] == wp_sync_q[2]) begin
        wp_lvl_q <= wp_sync_q[2];
      end
    end
  end

  // the captured command is frozen while cs_b is high, so it is safe to read
  assign frame_end = !cs_lvl_q && cs_sync_q[1] == cs_sync_q[2] && cs_sync_q[2];
  always_ff @(posedge clk or negedge rst_b) begin // see R11
    if (!rst_b) begin
      puw_cnt_q <= 13'h0000;
      puw_done_q <= 1'b0;
    end else if (!puw_done_q) begin
      puw_cnt_q <= puw_cnt_q + 13'h0001;
      puw_done_q <= puw_cnt_q >= 13'(PUW_CYC - 1);
    end
  end
  logic take;
  logic whole;
  logic stat_wr_ok;
  logic is_write;
  logic [23:0] load_cyc;
  always_comb begin
    take = frame_end && cmd_q.valid && op_allowed(cmd_q.op, deep_q, busy);
    whole = cmd_q.bit_mod == 3'd0; // see R23
    // quad-line pin role: protect input only while quad_lines_enable is low
    if (lock_hi_q && lock_lo_q) begin
      stat_wr_ok = 1'b0; // see R19
    end else if (lock_hi_q) begin
      stat_wr_ok = 1'b0; // see R18
    end else if (lock_lo_q) begin
      stat_wr_ok = quad_lines_enable_q || wp_lvl_q; // see R17 R20
    end else begin
      stat_wr_ok = 1'b1; // see R17
    end
    is_write = cmd_q.op == `SFMS_OP_PAGE_PROG || cmd_q.op == `SFMS_OP_ERASE_4K ||
               cmd_q.op == `SFMS_OP_ERASE_32K || cmd_q.op == `SFMS_OP_ERASE_64K ||
               cmd_q.op == `SFMS_OP_ERASE_CHIP_A || cmd_q.op == `SFMS_OP_ERASE_CHIP_B ||
               cmd_q.op == `SFMS_OP_WR_SECURITY;
    if (cmd_q.op == `SFMS_OP_PAGE_PROG || cmd_q.op == `SFMS_OP_WR_SECURITY) begin
      load_cyc = 24'(PROG_CYC);
    end else begin
      load_cyc = 24'(ERASE_CYC);
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wpl_q <= 1'b0; // see R13
      lock_lo_q <= 1'b0; // see R18
      lock_hi_q <= 1'b0;
      quad_lines_enable_q <= 1'b0;
      four_q <= 1'b0; // see R9
      deep_q <= 1'b0;
      rst_arm_q <= 1'b0;
      op_st_q <= SFMS_IDLE; // see R22
      busy_cnt_q <= 24'h000000;
    end else begin
      if (op_st_q == SFMS_RUN) begin
        if (busy_cnt_q <= 24'h000001) begin
          op_st_q <= SFMS_IDLE; // see R15
        end
        busy_cnt_q <= busy_cnt_q - 24'h000001;
      end
      if (take) begin
        rst_arm_q <= cmd_q.op == `SFMS_OP_RESET_ARM;
        if (cmd_q.op == `SFMS_OP_WR_ENABLE) begin
          if (puw_done_q) begin
            wpl_q <= 1'b1; // see R11 R12
          end
        end else if (cmd_q.op == `SFMS_OP_WR_DISABLE) begin
          wpl_q <= 1'b0; // see R13
        end else if (cmd_q.op == `SFMS_OP_WR_STAT || cmd_q.op == `SFMS_OP_WR_STAT_HI) begin
          if (whole && wpl_q && puw_done_q && stat_wr_ok && cmd_q.nbytes >= 3'd2) begin
            wpl_q <= 1'b0; // see R13
            op_st_q <= SFMS_RUN; // see R15
            busy_cnt_q <= 24'(WSR_CYC);
            // only lock and quad bits are writable; the reserved bits read zero
            if (cmd_q.op == `SFMS_OP_WR_STAT) begin
              lock_lo_q <= cmd_q.b1[`SFMS_BIT_LOCK_LO]; // see R24
              if (cmd_q.nbytes >= 3'd3) begin
                lock_hi_q <= cmd_q.b2[`SFMS_BIT_LOCK_HI];
                quad_lines_enable_q <= cmd_q.b2[`SFMS_BIT_QLE];
              end
            end else begin
              lock_hi_q <= cmd_q.b1[`SFMS_BIT_LOCK_HI];
              quad_lines_enable_q <= cmd_q.b1[`SFMS_BIT_QLE];
            end
          end
        end else if (is_write) begin
          if (whole && wpl_q && puw_done_q) begin // see R23
            wpl_q <= 1'b0; // see R13
            op_st_q <= SFMS_RUN; // see R15
            busy_cnt_q <= load_cyc;
          end
        end else if (cmd_q.op == `SFMS_OP_SUSPEND) begin
          if (busy) begin
            op_st_q <= SFMS_HELD; // see R22
          end
        end else if (cmd_q.op == `SFMS_OP_RESUME) begin
          if (paused) begin
            op_st_q <= SFMS_RUN; // see R22
          end
        end else if (cmd_q.op == `SFMS_OP_DEEP_DOWN) begin
          deep_q <= 1'b1; // see R14
        end else if (cmd_q.op == `SFMS_OP_DEEP_RELEASE) begin
          deep_q <= 1'b0; // see R14
        end else if (cmd_q.op == `SFMS_OP_ENTER_FOUR) begin
          if (quad_lines_enable_q) begin
            four_q <= 1'b1; // see R7
          end
        end else if (cmd_q.op == `SFMS_OP_LEAVE_FOUR) begin
          four_q <= 1'b0; // see R9
        end else if (cmd_q.op == `SFMS_OP_RESET_GO) begin
          if (rst_arm_q) begin
            four_q <= 1'b0; // see R9
            wpl_q <= 1'b0;
            op_st_q <= SFMS_IDLE;
          end
        end
      end
    end
  end

  // status image, one cycle behind the bits it reflects
  logic [15:0] status_q;
  logic four_out_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status_q <= 16'h0000;
      four_out_q <= 1'b0;
    end else begin
      four_out_q <= four_q;
      status_q <= 16'h0000; // see R24
      status_q[`SFMS_BIT_BUSY] <= busy; // see R15
      status_q[`SFMS_BIT_WPL] <= wpl_q; // see R12
      status_q[`SFMS_BIT_LOCK_LO] <= lock_lo_q;
      status_q[8 + `SFMS_BIT_LOCK_HI] <= lock_hi_q;
      status_q[8 + `SFMS_BIT_QLE] <= quad_lines_enable_q;
      status_q[8 + `SFMS_BIT_PAUSED] <= paused; // see R22
    end
  end

  assign status = status_q;
  assign four_line_command_mode = four_out_q;

endmodule
`default_nettype wire

// ---- hw/sfms_defines.svh ----
// opcodes, status bit positions and timing constants of the serial flash status block
`ifndef SFMS_DEFINES_SVH
`define SFMS_DEFINES_SVH

`define SFMS_OP_WR_ENABLE 8'h06
`define SFMS_OP_WR_DISABLE 8'h04
`define SFMS_OP_RD_STAT_LO 8'h05
`define SFMS_OP_RD_STAT_HI 8'h35
`define SFMS_OP_WR_STAT 8'h01
`define SFMS_OP_WR_STAT_HI 8'h31
`define SFMS_OP_PAGE_PROG 8'h02
`define SFMS_OP_ERASE_4K 8'h20
`define SFMS_OP_ERASE_32K 8'h52
`define SFMS_OP_ERASE_64K 8'hd8
`define SFMS_OP_ERASE_CHIP_A 8'h60
`define SFMS_OP_ERASE_CHIP_B 8'hc7
`define SFMS_OP_WR_SECURITY 8'h2f
`define SFMS_OP_SUSPEND 8'h75
`define SFMS_OP_RESUME 8'h7a
`define SFMS_OP_DEEP_DOWN 8'hb9
`define SFMS_OP_DEEP_RELEASE 8'hab
`define SFMS_OP_RESET_ARM 8'h66
`define SFMS_OP_RESET_GO 8'h99
`define SFMS_OP_ENTER_FOUR 8'h38
`define SFMS_OP_LEAVE_FOUR 8'hff
`define SFMS_OP_DUAL_READ 8'h3b
`define SFMS_OP_QUAD_READ 8'h6b

`define SFMS_BIT_BUSY 0
`define SFMS_BIT_WPL 1
`define SFMS_BIT_LOCK_LO 7
`define SFMS_BIT_LOCK_HI 0
`define SFMS_BIT_QLE 1
`define SFMS_BIT_PAUSED 7

`define SFMS_FILL_BYTE 8'hff
`define SFMS_DATA_START_CLKS 7'h28

`define SFMS_CLK_NS 8
`define SFMS_PUW_NS 10000
`define SFMS_WSR_NS 8000
`define SFMS_PROG_NS 8000
`define SFMS_ERASE_NS 16000

`endif

// ---- hw/sfms_pkg.sv ----
// types shared by the serial flash status and mode block
package sfms_pkg;

  // command as captured by the link side, read by the core at frame end
  typedef struct packed {
    logic [7:0] op;
    logic valid;
    logic [2:0] nbytes;
    logic [2:0] bit_mod;
    logic [7:0] b1;
    logic [7:0] b2;
  } sfms_cmd_t;

  typedef enum logic [1:0] {
    SFMS_IDLE,
    SFMS_RUN,
    SFMS_HELD
  } sfms_op_t;

endpackage

// ---- verification/sfms_core_checker.sv ----
// assertion checker for the serial flash status and mode block
`timescale 1ns/1ns
`default_nettype none
module sfms_core_checker #(
  parameter int PUW_CYC = 1250,
  parameter int ERASE_CYC = 2000
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sck,
  input wire logic cs_b,
  input wire logic [3:0] io_in,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe,
  input wire logic [15:0] status,
  input wire logic four_line_command_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  int puw_q;
  int busy_q;
  // busy bound assumes erase is the longest internal operation
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      puw_q <= 0;
      busy_q <= 0;
    end else begin
      puw_q <= (puw_q < PUW_CYC) ? puw_q + 1 : puw_q;
      busy_q <= status[0] ? busy_q + 1 : 0;
    end
  end
  sequence s_cs_rise;
    $rose(cs_b);
  endsequence
  sequence s_latch_set;
    $rose(status[1]);
  endsequence
  a_rst_quiet: assert property ($rose(rst_b) |-> status == 16'h0 && !four_line_command_mode)
    else $error("state not clear after reset");
  a_oe_release: assert property (s_cs_rise |-> (io_oe == 4'h0) [*3])
    else $error("output enable held after deselect");
  a_puw_guard: assert property (s_latch_set |-> puw_q >= PUW_CYC)
    else $error("latch set inside power-up delay");
  a_we_idle: assert property (s_latch_set |-> cs_b && !status[0])
    else $error("latch set while busy or selected");
  a_busy_bound: assert property (busy_q <= ERASE_CYC + 4)
    else $error("busy held too long");
  a_pause_excl: assert property (!(status[15] && status[0]))
    else $error("paused and busy together");
  a_lock_gate: assert property ($changed(status[8:7]) |-> $past(status[1]))
    else $error("lock bits changed without latch");
  a_lock_hold: assert property (status[8] |=> $stable(status[9:7]))
    else $error("locked status bits changed");
  a_four_qe: assert property ($rose(four_line_command_mode) |-> status[9])
    else $error("four-line mode without quad enable");
  a_reserved_zero: assert property (status[14:10] == 5'h0 && status[6:2] == 5'h0)
    else $error("reserved status bit set");
endmodule
bind sfms_core sfms_core_checker #(.PUW_CYC(PUW_CYC), .ERASE_CYC(ERASE_CYC)) chk_i (
  .clk(clk), .rst_b(rst_b), .sck(sck), .cs_b(cs_b), .io_in(io_in), .io_out(io_out),
  .io_oe(io_oe), .status(status), .four_line_command_mode(four_line_command_mode));
`default_nettype wire

// ---- verification/sfms_host.sv ----
// host-side serial master model for the flash status block
`timescale 1ns/1ns
`default_nettype none
module sfms_host (
  output logic sck,
  output logic cs_b,
  output logic [3:0] io_in,
  input wire logic [3:0] io_out,
  input wire logic wp_lvl
);
  initial begin
    sck = 1'b0;
    cs_b = 1'b1;
    io_in = 4'hd;
  end
  // mode 0 only: sck rests low at both select edges
  // n may stop mid-byte on purpose to abort a write
  task automatic frame(input logic [31:0] d, input int n, input int w, input int nrd,
                       output logic [15:0] rd);
    rd = 16'h0;
    cs_b = 1'b0;
    for (int i = 0; i < n + nrd; i++) begin
      // released lines toggle so stale data never passes as valid
      if (i >= n) io_in = (w == 4) ? ~io_in : {1'b1, wp_lvl, ~io_in[1:0]};
      else if (w == 4) io_in = d[31:28];
      else io_in = {1'b1, wp_lvl, ~io_in[1], d[31]};
      d = d << w;
      #15 sck = 1'b1;
      if (i >= n) rd = (w == 4) ? {rd[11:0], io_out} : {rd[14:0], io_out[1]};
      #15 sck = 1'b0;
    end
    #15 cs_b = 1'b1;
    io_in = {1'b1, wp_lvl, ~io_in[1:0]};
    #60;
  endtask
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench for the serial flash status and mode block
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk = 1'b0, rst_b = 1'b0, wp_lvl = 1'b1, sck, cs_b, four_line_command_mode;
  logic [3:0] io_in, io_out, io_oe;
  logic [15:0] status, rd, m = 16'h0;
  logic [31:0] lfsr = 32'h73e03677;
  int mismatches = 0, cmp_count = 0;
  initial forever #4 clk = ~clk;
  sfms_core #(.PUW_CYC(100), .WSR_CYC(80), .PROG_CYC(80), .ERASE_CYC(120)) sfms_core_i (
    .clk(clk), .rst_b(rst_b), .sck(sck), .cs_b(cs_b), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe), .status(status), .four_line_command_mode(four_line_command_mode));
  sfms_host sfms_host_i (.sck(sck), .cs_b(cs_b), .io_in(io_in), .io_out(io_out),
    .wp_lvl(wp_lvl));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // settle time lets the clk side sync the deselect and act
  task automatic go(input logic [31:0] d, input int n, input int w = 1, input int nrd = 0);
    @(negedge clk);
    sfms_host_i.frame(d, n, w, nrd, rd);
    repeat (8) @(negedge clk);
  endtask
  task automatic op(input logic [7:0] c);
    go({c, 24'h0}, 8);
  endtask
  task automatic wi();
    for (int k = 0; k < 300 && status[0] !== 1'b0; k++) @(negedge clk);
    m[0] = 1'b0;
  endtask
  task automatic sr();
    go(32'h05000000, 8, 1, 8);
    chk(rd, {8'h0, m[7:0]});
    chk(status, m);
  endtask
  initial begin
    #100000;
    mismatches++;
    print_verdict();
  end
  initial begin
    repeat (2) @(negedge clk);
    chk(status, m);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    op(8'h06);
    chk(status, m);
    repeat (60) @(negedge clk);
    op(8'h06);
    m[1] = 1'b1;
    sr();
    op(8'h04);
    m[1] = 1'b0;
    sr();
    go(32'h6b000000, 40, 1, 4);
    chk(rd, 16'h0000);
    go(32'h3b000000, 40, 1, 4);
    chk(rd, 16'h000f);
    lfsr = nxt(lfsr);
    op(8'h06);
    go({8'h01, lfsr[7:0] & 8'h7f, 16'h0}, 16);
    m[0] = 1'b1;
    chk(status, m);
    op(8'h06);
    chk(status, m);
    wi();
    sr();
    op(8'h06);
    go(32'h01000000, 23);
    m[1] = 1'b1;
    sr();
    go(32'h01800000, 16);
    m = 16'h0081;
    wi();
    wp_lvl = 1'b0;
    op(8'h06);
    go(32'h01000000, 16);
    m = 16'h0082;
    sr();
    wp_lvl = 1'b1;
    go(32'h01000000, 16);
    m = 16'h0001;
    wi();
    sr();
    op(8'h06);
    go(32'h02000000, 32);
    chk(status, 16'h0001);
    op(8'h75);
    chk(status, 16'h8000);
    op(8'h7a);
    wi();
    chk(status, m);
    op(8'hb9);
    op(8'h06);
    chk(status, m);
    op(8'hab);
    op(8'h06);
    op(8'h38);
    chk({15'h0, four_line_command_mode}, 16'h0);
    go(32'h31020000, 16); // io2 and io3 are driven, never tied
    m = 16'h0201;
    wi();
    op(8'h38);
    chk({15'h0, four_line_command_mode}, 16'h1);
    go(32'h06000000, 2, 4);
    go(32'h05000000, 2, 4, 2);
    chk(rd, 16'h0002);
    go(32'h66000000, 2, 4);
    go(32'h99000000, 2, 4);
    chk({15'h0, four_line_command_mode}, 16'h0);
    op(8'h06);
    go(32'h31030000, 16);
    m = 16'h0301;
    wi();
    op(8'h06);
    go(32'h31000000, 16);
    m[1] = 1'b1;
    sr();
    go(32'h6b000000, 40, 1, 4);
    chk(rd, 16'h000f);
    print_verdict();
  end
endmodule
`default_nettype wire
